// ===== bench/adc_control_asserts.sv
`timescale 1ns/1ps
// port-level checks of channel decode and completion request
module adc_control_asserts (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        ARST_N,
	// apb
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	// converter side
	input wire logic        STOP_MODE,
	input wire logic [4:0]  CHANNEL_SELECT,
	input wire logic        UPPER_REF_SEL,
	input wire logic        LOWER_REF_SEL,
	input wire logic        CONV_POWER_DOWN,
	input wire logic        CONV_IRQ
);
	import adc_ctrl_pkg::*;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	logic wr_ctl;
	logic rd_ctl;
	logic rd_res;
	// decoded access-phase strobes
	assign wr_ctl = PSEL && PENABLE && PWRITE && (PADDR == STATUS_CONTROL_OFFSET);
	assign rd_ctl = PSEL && PENABLE && !PWRITE && (PADDR == STATUS_CONTROL_OFFSET);
	assign rd_res = PSEL && PENABLE && !PWRITE
		&& (PADDR == RESULT_HIGH_OFFSET || PADDR == RESULT_LOW_OFFSET);
	// channel decode outputs
	a_power_down_code: assert property (CONV_POWER_DOWN == (CHANNEL_SELECT == CHAN_POWER_OFF))
		else $error("power down not tied to all-ones code");
	a_upper_ref_code: assert property (UPPER_REF_SEL == (CHANNEL_SELECT == CHAN_UPPER_REF))
		else $error("upper reference select wrong");
	a_lower_ref_code: assert property (LOWER_REF_SEL == (CHANNEL_SELECT == CHAN_LOWER_REF))
		else $error("lower reference select wrong");
	a_channel_follows: assert property (wr_ctl |=> CHANNEL_SELECT == $past(PWDATA[4:0]))
		else $error("channel field not taken from write");
	// completion request
	a_irq_write_clear: assert property (wr_ctl |=> !CONV_IRQ)
		else $error("request survived control write");
	a_irq_holds: assert property (CONV_IRQ && !wr_ctl && !rd_res |=> CONV_IRQ)
		else $error("request dropped without read or write");
	a_irq_no_flag: assert property (rd_ctl && CONV_IRQ |-> !PRDATA[DONE_FLAG_POS])
		else $error("done flag reads one with request enabled");
	a_conv_min_len: assert property (wr_ctl |=> !CONV_IRQ [*8])
		else $error("conversion finished too soon");
	a_stop_quiet: assert property (STOP_MODE [*4] |-> !$rose(CONV_IRQ))
		else $error("conversion completed in stop state");
	// main scenarios
	c_irq_rise: cover property ($rose(CONV_IRQ));
	c_result_read: cover property (rd_res && CONV_IRQ);
	c_stop_held: cover property (STOP_MODE [*4]);
endmodule : adc_control_asserts

// ===== bench/adc_control_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module adc_control_tb;
	import adc_ctrl_pkg::*;
	// bench-driven inputs
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic        osc_tick = 1'b0;
	logic        stop_mode = 1'b0;
	logic [9:0]  analog_code = 10'h2B5;
	// design outputs
	logic [31:0] prdata;
	logic        pready, pslverr, up_ref, lo_ref, pwr_dn, irq;
	logic [4:0]  chan_sel;
	// bench state
	int          err_total = 0;
	int          n_tests = 0;
	int          n;
	int          dv;
	logic        err_seen;
	logic [7:0]  q;
	logic [2:0]  p;
	logic [15:0] e16;
	// bus clock and an oscillator tick at half rate
	always #12.5 clk = ~clk;
	always @(posedge clk) osc_tick <= ~osc_tick;
	adc_control dut_u (
		.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.OSC_CLK_TICK(osc_tick), .STOP_MODE(stop_mode), .ANALOG_CODE(analog_code),
		.CHANNEL_SELECT(chan_sel), .UPPER_REF_SEL(up_ref), .LOWER_REF_SEL(lo_ref),
		.CONV_POWER_DOWN(pwr_dn), .CONV_IRQ(irq)
	);
	// one apb transfer, setup then access until ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] d_out);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		d_out = prdata[7:0];
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] unused_q;
		apb(1'b1, a, d, unused_q);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		apb(1'b0, a, 8'h00, v);
		`CHK(nm, e, v)
	endtask : rd_chk
	// count cycles until the request rises, sampled mid-cycle
	task automatic wait_irq(output int cnt);
		cnt = 0;
		while (irq !== 1'b1 && cnt < 2000) begin
			@(negedge clk);
			cnt++;
		end
		@(posedge clk);
	endtask : wait_irq
	// poll status until the done flag shows
	task automatic wait_flag();
		int k;
		k = 0;
		q = 8'h00;
		while (q[7] !== 1'b1 && k < 100) begin
			apb(1'b0, STATUS_CONTROL_OFFSET, 8'h00, q);
			k++;
		end
	endtask : wait_flag
	// expected high and low bytes for a format
	function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] c);
		case (f)
			2'h0: return {8'h00, c[9:2]};
			2'h1: return {6'h00, c};
			2'h2: return {c, 6'h00};
			default: return {~c[9], c[8:0], 6'h00};
		endcase
	endfunction : fmt_exp
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	// watchdog
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		results();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_chk("status_rst", STATUS_CONTROL_OFFSET, 8'h1F);
		rd_chk("clkcfg_rst", CLOCK_CONFIG_OFFSET, 8'h04);
		rd_chk("unmapped", 12'h010, 8'h00);
		`CHK("slverr", 1'b1, err_seen)
		// conversion length per prescale code, last pass oscillator /16 at 1.25 megahertz
		for (int i = 0; i < 7; i++) begin
			p = (i == 5) ? 3'h7 : ((i == 6) ? 3'h4 : 3'(i));
			dv = (i == 6) ? 32 : (p[2] ? 16 : (1 << p));
			wr(CLOCK_CONFIG_OFFSET, {p, i != 6, 2'h1, 2'h0});
			wr(STATUS_CONTROL_OFFSET, 8'h43);
			wait_irq(n);
			`CHK("conv_len", 1'b1, (n >= 16 * dv) && (n <= 17 * dv + 2))
			rd_chk("flag_off", STATUS_CONTROL_OFFSET, 8'h43);
			wr(STATUS_CONTROL_OFFSET, 8'h43);
			@(negedge clk);
			`CHK("irq_wr_clr", 1'b0, irq)
			@(posedge clk);
		end
		wait_irq(n);
		rd_chk("res_lo", RESULT_LOW_OFFSET, 8'hB5);
		@(negedge clk);
		`CHK("irq_rd_clr", 1'b0, irq)
		@(posedge clk);
		// stop state aborts a single conversion
		wr(CLOCK_CONFIG_OFFSET, 8'h14);
		wr(STATUS_CONTROL_OFFSET, 8'h43);
		repeat (5) @(posedge clk);
		stop_mode <= 1'b1;
		repeat (10) @(posedge clk);
		stop_mode <= 1'b0;
		repeat (60) @(posedge clk);
		`CHK("stop_abort", 1'b0, irq)
		// every result format
		for (int f = 0; f < 4; f++) begin
			e16 = fmt_exp(2'(f), 10'h2B5);
			wr(CLOCK_CONFIG_OFFSET, {4'h1, 2'(f), 2'h0});
			wr(STATUS_CONTROL_OFFSET, 8'h03);
			wait_flag();
			`CHK("flag_set", 8'h83, q)
			rd_chk("res_hi", RESULT_HIGH_OFFSET, e16[15:8]);
			rd_chk("res_lo", RESULT_LOW_OFFSET, e16[7:0]);
			rd_chk("flag_clr", STATUS_CONTROL_OFFSET, 8'h03);
		end
		repeat (40) @(posedge clk);
		rd_chk("one_shot", STATUS_CONTROL_OFFSET, 8'h03);
		// continuous mode with the high/low interlock
		wr(CLOCK_CONFIG_OFFSET, 8'h14);
		wr(STATUS_CONTROL_OFFSET, 8'h23);
		repeat (40) @(posedge clk);
		rd_chk("cont_hi", RESULT_HIGH_OFFSET, 8'h02);
		analog_code <= 10'h1CA;
		repeat (60) @(posedge clk);
		rd_chk("frozen_lo", RESULT_LOW_OFFSET, 8'hB5);
		repeat (40) @(posedge clk);
		rd_chk("cont_hi2", RESULT_HIGH_OFFSET, 8'h01);
		rd_chk("cont_lo2", RESULT_LOW_OFFSET, 8'hCA);
		// stop in continuous mode: nothing completes inside, converting resumes after exit
		stop_mode <= 1'b1;
		rd_chk("stop_lo", RESULT_LOW_OFFSET, 8'hCA);
		repeat (40) @(posedge clk);
		rd_chk("stop_flag", STATUS_CONTROL_OFFSET, 8'h23);
		stop_mode <= 1'b0;
		wait_flag();
		`CHK("resume", 8'hA3, q)
		// control write mid-conversion restarts; the aborted result never lands
		wr(STATUS_CONTROL_OFFSET, 8'h05);
		rd_chk("resume_lo", RESULT_LOW_OFFSET, 8'hCA);
		wr(STATUS_CONTROL_OFFSET, 8'h06);
		repeat (14) @(posedge clk);
		rd_chk("restart_early", STATUS_CONTROL_OFFSET, 8'h06);
		wait_flag();
		`CHK("restart_done", 8'h86, q)
		// channel codes
		wr(STATUS_CONTROL_OFFSET, 8'h1F);
		`CHK("pwr_dn", 1'b1, pwr_dn)
		wr(STATUS_CONTROL_OFFSET, 8'h1D);
		`CHK("up_ref", 1'b1, up_ref)
		wr(STATUS_CONTROL_OFFSET, 8'h1E);
		`CHK("lo_ref", 1'b1, lo_ref)
		wr(STATUS_CONTROL_OFFSET, 8'h07);
		`CHK("chan", 5'h07, chan_sel)
		wr(STATUS_CONTROL_OFFSET, 8'h08);
		`CHK("unused_ch", 8'h08, {up_ref, lo_ref, pwr_dn, chan_sel})
		results();
	end
endmodule : adc_control_tb
bind adc_control adc_control_asserts chk_u (.CORE_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .PRDATA, .STOP_MODE, .CHANNEL_SELECT, .UPPER_REF_SEL, .LOWER_REF_SEL,
	.CONV_POWER_DOWN, .CONV_IRQ);

// ===== verilog/adc_control.sv
`timescale 1ns/1ps
// converter control, result formatting and apb register file
module adc_control (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// clock sources and low power
	input  wire logic        OSC_CLK_TICK,
	input  wire logic        STOP_MODE,
	// analog side
	input  wire logic [9:0]  ANALOG_CODE,
	output logic      [4:0]  CHANNEL_SELECT,
	output logic             UPPER_REF_SEL,
	output logic             LOWER_REF_SEL,
	output logic             CONV_POWER_DOWN,
	// interrupt request
	output logic             CONV_IRQ
);
	import adc_ctrl_pkg::*;

	sar_core_if core_c ();

	logic        conv_done_flag_reg;
	logic        conv_irq_enable_reg;
	logic        continuous_conv_reg;
	logic [4:0]  channel_select_reg;
	logic [2:0]  clock_prescale_reg;
	logic        input_clock_select_reg;
	format_type  format_reg;
	logic [7:0]  result_high_reg;
	logic [7:0]  result_low_reg;
	logic        low_frozen_reg;
	logic        irq_reg;
	logic        pending_reg;
	logic        stop_seen_reg;
	logic [3:0]  div_count_reg;
	logic        conv_tick_reg;

	logic        wr_en;
	logic        rd_en;
	logic        wr_sc;
	logic        wr_clk;
	logic        rd_high;
	logic        rd_low;
	logic        result_read;
	logic        powered;
	logic        src_tick;
	logic [3:0]  div_mask;
	logic [7:0]  status_rd;
	logic [7:0]  clock_rd;
	logic        store_ok;
	logic        stop_exit;

	// apb decode; zero-wait answers
	assign wr_en   = PSEL && PENABLE && PWRITE;
	assign rd_en   = PSEL && PENABLE && !PWRITE;
	assign wr_sc   = wr_en && PADDR == STATUS_CONTROL_OFFSET;
	assign wr_clk  = wr_en && PADDR == CLOCK_CONFIG_OFFSET;
	assign rd_high = rd_en && PADDR == RESULT_HIGH_OFFSET;
	assign rd_low  = rd_en && PADDR == RESULT_LOW_OFFSET;
	assign result_read = rd_high || rd_low;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && PADDR != STATUS_CONTROL_OFFSET
		&& PADDR != RESULT_HIGH_OFFSET && PADDR != RESULT_LOW_OFFSET
		&& PADDR != CLOCK_CONFIG_OFFSET;

	// done flag reads zero with irq enabled
	assign status_rd = {conv_done_flag_reg && !conv_irq_enable_reg,
		conv_irq_enable_reg, continuous_conv_reg, channel_select_reg};
	assign clock_rd  = {clock_prescale_reg, input_clock_select_reg, format_reg, 2'h0};

	// read data mux, registered
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			unique case (PADDR)
				STATUS_CONTROL_OFFSET: PRDATA <= {24'h00_0000, status_rd};
				RESULT_HIGH_OFFSET:    PRDATA <= {24'h00_0000, result_high_reg};
				RESULT_LOW_OFFSET:     PRDATA <= {24'h00_0000, result_low_reg};
				CLOCK_CONFIG_OFFSET:   PRDATA <= {24'h00_0000, clock_rd};
				default:               PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// status/control register; done flag bit of the write is ignored
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			conv_irq_enable_reg <= STATUS_CONTROL_RESET[IRQ_EN_POS];
			continuous_conv_reg <= STATUS_CONTROL_RESET[CONT_POS];
			channel_select_reg  <= STATUS_CONTROL_RESET[CHAN_LSB +: CHAN_W];
		end else if (wr_sc) begin
			conv_irq_enable_reg <= PWDATA[IRQ_EN_POS];
			continuous_conv_reg <= PWDATA[CONT_POS];
			channel_select_reg  <= PWDATA[CHAN_LSB +: CHAN_W];
		end
	end

	// clock config register
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			clock_prescale_reg     <= CLOCK_CONFIG_RESET[PRESCALE_LSB +: PRESCALE_W];
			input_clock_select_reg <= CLOCK_CONFIG_RESET[CLK_SEL_POS];
			format_reg             <= format_type'(CLOCK_CONFIG_RESET[FORMAT_LSB +: 2]);
		end else if (wr_clk) begin
			clock_prescale_reg     <= PWDATA[PRESCALE_LSB +: PRESCALE_W];
			input_clock_select_reg <= PWDATA[CLK_SEL_POS];
			format_reg             <= format_type'(PWDATA[FORMAT_LSB +: 2]);
		end
	end

	// conversion clock divider on the chosen source tick
	assign src_tick = input_clock_select_reg ? 1'b1 : OSC_CLK_TICK;
	always_comb begin
		unique casez (clock_prescale_reg)
			3'b000:  div_mask = 4'h0;
			3'b001:  div_mask = 4'h1;
			3'b010:  div_mask = 4'h3;
			3'b011:  div_mask = 4'h7;
			default: div_mask = 4'hF;
		endcase
	end
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_count_reg <= 4'h0;
			conv_tick_reg <= 1'b0;
		end else begin
			conv_tick_reg <= 1'b0;
			if (src_tick) begin
				if ((div_count_reg & div_mask) == div_mask) begin
					div_count_reg <= 4'h0;
					conv_tick_reg <= 1'b1;
				end else begin
					div_count_reg <= div_count_reg + 4'h1;
				end
			end
		end
	end

	// channel routing and power down
	assign powered         = channel_select_reg != CHAN_POWER_OFF;
	assign CONV_POWER_DOWN = !powered;
	assign CHANNEL_SELECT  = channel_select_reg;
	assign UPPER_REF_SEL   = channel_select_reg == CHAN_UPPER_REF;
	assign LOWER_REF_SEL   = channel_select_reg == CHAN_LOWER_REF;

	// start request: control write, continuous rerun, or stop exit in continuous mode
	assign stop_exit = stop_seen_reg && !STOP_MODE;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pending_reg   <= 1'b0;
			stop_seen_reg <= 1'b0;
		end else begin
			stop_seen_reg <= STOP_MODE;
			if (wr_sc) begin
				pending_reg <= 1'b1;
			end else if (stop_exit && continuous_conv_reg) begin
				pending_reg <= 1'b1;
			end else if (core_c.done && continuous_conv_reg) begin
				pending_reg <= 1'b1;
			end else if (core_c.start || STOP_MODE) begin
				pending_reg <= 1'b0;
			end
		end
	end
	// launch on a conversion clock tick so length is 16 to 17 ticks
	assign core_c.start = pending_reg && conv_tick_reg && powered && !STOP_MODE && !wr_sc;
	assign core_c.abort = STOP_MODE || !powered || wr_sc;

	sar_sequencer u_seq (
		.clk         (CORE_CLK),
		.arst_n      (ARST_N),
		.conv_tick   (conv_tick_reg),
		.analog_code (ANALOG_CODE),
		.port_c      (core_c)
	);

	// result store, blocked while the low half is frozen
	assign store_ok = core_c.done && !(low_frozen_reg && format_reg != FMT_TRUNC);
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			result_high_reg <= 8'h00;
			result_low_reg  <= 8'h00;
		end else if (store_ok) begin
			unique case (format_reg)
				FMT_TRUNC: begin
					result_high_reg <= 8'h00;
					result_low_reg  <= core_c.result[9:2];
				end
				FMT_RIGHT: begin
					result_high_reg <= {6'h00, core_c.result[9:8]};
					result_low_reg  <= core_c.result[7:0];
				end
				FMT_LEFT: begin
					result_high_reg <= core_c.result[9:2];
					result_low_reg  <= {core_c.result[1:0], 6'h00};
				end
				FMT_SIGNED: begin
					result_high_reg <= {~core_c.result[9], core_c.result[8:2]};
					result_low_reg  <= {core_c.result[1:0], 6'h00};
				end
			endcase
		end
	end

	// interlock outside truncated format: high read freezes low until low read
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			low_frozen_reg <= 1'b0;
		end else if (rd_low || format_reg == FMT_TRUNC) begin
			low_frozen_reg <= 1'b0;
		end else if (rd_high) begin
			low_frozen_reg <= 1'b1;
		end
	end

	// done flag and irq; a done in the clearing cycle wins
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			conv_done_flag_reg <= 1'b0;
			irq_reg            <= 1'b0;
		end else begin
			if (store_ok && !conv_irq_enable_reg) begin
				conv_done_flag_reg <= 1'b1;
			end else if (result_read || conv_irq_enable_reg) begin
				conv_done_flag_reg <= 1'b0;
			end
			if (store_ok && conv_irq_enable_reg) begin
				irq_reg <= 1'b1;
			end else if (result_read || wr_sc || !conv_irq_enable_reg) begin
				irq_reg <= 1'b0;
			end
		end
	end
	assign CONV_IRQ = irq_reg;
endmodule : adc_control

// ===== verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	// register byte addresses
	localparam logic [11:0] STATUS_CONTROL_OFFSET = 12'h000;
	localparam logic [11:0] RESULT_HIGH_OFFSET    = 12'h004;
	localparam logic [11:0] RESULT_LOW_OFFSET     = 12'h008;
	localparam logic [11:0] CLOCK_CONFIG_OFFSET   = 12'h00C;
	// status/control fields
	localparam int DONE_FLAG_POS  = 7;
	localparam int IRQ_EN_POS     = 6;
	localparam int CONT_POS       = 5;
	localparam int CHAN_LSB       = 0;
	localparam int CHAN_W         = 5;
	// clock config fields
	localparam int PRESCALE_LSB   = 5;
	localparam int PRESCALE_W     = 3;
	localparam int CLK_SEL_POS    = 4;
	localparam int FORMAT_LSB     = 2;
	// reset values
	localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1F;
	localparam logic [7:0] CLOCK_CONFIG_RESET   = 8'h04;
	// channel codes
	localparam logic [4:0] CHAN_UPPER_REF = 5'h1D;
	localparam logic [4:0] CHAN_LOWER_REF = 5'h1E;
	localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
	localparam logic [4:0] CHAN_LAST_EXT  = 5'h07;
	// conversion length in conversion clocks
	localparam int CONV_CYCLES = 16;
	// result formats
	typedef enum logic [1:0] {
		FMT_TRUNC  = 2'h0,
		FMT_RIGHT  = 2'h1,
		FMT_LEFT   = 2'h2,
		FMT_SIGNED = 2'h3
	} format_type;
endpackage : adc_ctrl_pkg

// ===== verilog/sar_core_if.sv
`timescale 1ns/1ps
// start/abort and result strobe between control logic and sar sequencer
interface sar_core_if;
	logic       start;
	logic       abort;
	logic       busy;
	logic       done;
	logic [9:0] result;
	modport ctrl (output start, output abort, input busy, input done, input result);
	modport core (input start, input abort, output busy, output done, output result);
endinterface : sar_core_if

// ===== verilog/sar_sequencer.sv
`timescale 1ns/1ps
// counts conversion clock ticks, samples converter output, strobes done
module sar_sequencer (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   arst_n,
	// conversion clock tick
	input  wire logic   conv_tick,
	// analog converter output for the selected input
	input  wire logic [9:0] analog_code,
	// control side
	sar_core_if.core    port_c
);
	import adc_ctrl_pkg::*;

	logic [4:0] count_reg;
	logic       busy_reg;
	logic       done_reg;
	logic [9:0] result_reg;

	// sequencing: 16 ticks after start; start waits for the first tick
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= 5'h00;
			busy_reg  <= 1'b0;
		end else if (port_c.abort || port_c.start) begin
			count_reg <= 5'h00;
			busy_reg  <= port_c.start && !port_c.abort;
		end else if (busy_reg && conv_tick) begin
			if (count_reg == 5'(CONV_CYCLES - 1)) begin
				busy_reg  <= 1'b0;
				count_reg <= 5'h00;
			end else begin
				count_reg <= count_reg + 5'h01;
			end
		end
	end

	// one-cycle done strobe with the sampled code
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_reg   <= 1'b0;
			result_reg <= 10'h000;
		end else begin
			done_reg <= busy_reg && conv_tick && !port_c.abort && !port_c.start
				&& count_reg == 5'(CONV_CYCLES - 1);
			if (busy_reg && conv_tick && count_reg == 5'(CONV_CYCLES - 1)) begin
				result_reg <= analog_code;
			end
		end
	end

	assign port_c.busy   = busy_reg;
	assign port_c.done   = done_reg;
	assign port_c.result = result_reg;
endmodule : sar_sequencer
